// [tfv_regs.vh]
`ifndef TFV_REGS_VH
`define TFV_REGS_VH
// ==========================================
// Register offsets
`define TFV_A_CFG 8'h00
`define TFV_A_FRAC 8'h06
`define TFV_A_FAN1 8'h08
`define TFV_A_FAN2 8'h09
`define TFV_A_T_LOC 8'h0a
`define TFV_A_T_R1 8'h0b
`define TFV_A_T_R2 8'h0c
`define TFV_A_OFS_LOC 8'h0d
`define TFV_A_OFS_R1 8'h0e
`define TFV_A_OFS_R2 8'h0f
`define TFV_A_SLOW1 8'h10
`define TFV_A_SLOW2 8'h11
`define TFV_A_LOC_UP 8'h14
`define TFV_A_LOC_LO 8'h15
`define TFV_A_LOC_CR 8'h16
`define TFV_A_R1_UP 8'h18
`define TFV_A_R1_LO 8'h19
`define TFV_A_R1_CR 8'h1a
`define TFV_A_R2_UP 8'h1c
`define TFV_A_R2_LO 8'h1d
`define TFV_A_R2_CR 8'h1e
// ==========================================
// Reset values (limits in degrees, 1 per LSB)
`define TFV_CFG_RST 8'h90
`define TFV_OFS_RST 8'h00
`define TFV_SLOW_RST 8'hff
`define TFV_LOC_UP_RST 8'h3c
`define TFV_LOC_LO_RST 8'h00
`define TFV_LOC_CR_RST 8'h46
`define TFV_REM_UP_RST 8'h50
`define TFV_REM_LO_RST 8'h00
`define TFV_REM_CR_RST 8'h64
`define TFV_ZERO8 8'h00
// ==========================================
// Configuration fields
`define TFV_B_MON 0
`define TFV_B_INTEN 1
`define TFV_B_SENSE 2
`define TFV_B_INV 3
`define TFV_B_FFEN 4
`define TFV_B_MAP_LO 5
`define TFV_B_MAP_HI 6
`define TFV_B_AUTO 7
`define TFV_MAP_SPLIT 2'h0
`define TFV_MAP_R1 2'h1
`define TFV_MAP_R2 2'h2
`define TFV_MAP_MAX 2'h3
`define TFV_SRC_LOC 2'h0
`define TFV_SRC_R1 2'h1
`define TFV_SRC_R2 2'h2
`define TFV_SRC_MAX 2'h3
// ==========================================
// Arithmetic limits and bus constants
`define TFV_TACH_SAT 8'hff
`define TFV_TEMP_MAX 8'h7f
`define TFV_TEMP_MIN 8'h80
`define TFV_DEV_ADDR 7'h2c
`define TFV_BIT_LAST 4'h8
`define TFV_BIT_ZERO 4'h0
`define TFV_BIT_ONE 4'h1
`endif

// [tfv_value_config.v]
// Contract
// RULE_01 - Fan one and two tach counts at 0x08/0x09, readable and writable.
// RULE_02 - Upper eight bits of three temperature readings, read only, 0x0a-0x0c.
// RULE_03 - Read-only register with extra low-order temperature bits at 0x06.
// RULE_04 - Three writable temperature offsets, zero after power-on.
// RULE_05 - Tach count is pulse interval; count above slow limit flags slow fan.
// RULE_06 - Both fan slow limits reset to all ones.
// RULE_07 - On-chip limits default to 60, 0 and 70 degrees.
// RULE_08 - Remote one limits default to 80, 0 and 100 degrees.
// RULE_09 - Remote two limits default to 80, 0 and 100 degrees.
// RULE_10 - Config bit 0 runs measurement; resets to zero, stopped.
// RULE_11 - Config bit 1 enables interrupt output; resets to zero.
// RULE_12 - Config bit 2 selects digital tach or analog sense; resets zero.
// RULE_13 - Config bit 3 inverts both fan drive outputs; resets zero.
// RULE_14 - Config bit 4 enables fan-failure pin; resets to one.
// RULE_15 - Automatic mode: bits 6-5 map channels to fans, 11 uses hottest.
// RULE_16 - Software mode: 00 direct duty, 11 target speeds.
// RULE_17 - Config bit 7 selects automatic control; resets to one.
// RULE_18 - Configuration register loads 0x90 at power-on.
// RULE_19 - Tach count saturates at 255 when no valid interval is seen.
// RULE_20 - Tach count above limit raises interrupt when the output is enabled.
// RULE_21 - Limits and offsets are signed eight-bit, one degree per LSB.
`timescale 1ns/1ps
`default_nettype none
`include "tfv_regs.vh"
module tfv_value_config (
	input wire clock_in, // 200 MHz device clock
	input wire rst_in, // Synchronous reset, high
	input wire scl_in, // Management bus clock pin
	input wire sda_in, // Management bus data pin level
	output reg sda_out, // Data pin drive level, always low
	output reg sda_oe_out, // Data pin pull-down enable
	input wire [15:0] fan1_interval_in, // Fan one pulse interval
	input wire [15:0] fan2_interval_in, // Fan two pulse interval
	input wire [1:0] fan_valid_in, // Interval update strobes
	input wire [1:0] fan_stall_in, // No pulse seen, per fan
	input wire [7:0] temp_loc_in, // On-chip reading, upper bits
	input wire [7:0] temp_r1_in, // Remote one reading
	input wire [7:0] temp_r2_in, // Remote two reading
	input wire [7:0] temp_frac_in, // Low-order resolution bits
	input wire temp_valid_in, // Temperature update strobe
	input wire [1:0] fan_drive_in, // Raw fan drive waveforms
	output reg [1:0] fan_drive_out, // Fan drive after polarity
	output reg monitor_enable_out, // Measurement running
	output reg speed_sense_select_out, // 1 = analog sense inputs
	output reg fan_fault_enable_out, // Fan-failure pin enabled
	output reg automatic_control_select_out, // 1 = automatic
	output reg [1:0] fan1_source_out, // Channel steering fan one
	output reg [1:0] fan2_source_out, // Channel steering fan two
	output reg [7:0] fan1_control_temp_out, // Temperature for fan one
	output reg [7:0] fan2_control_temp_out, // Temperature for fan two
	output reg sw_duty_mode_out, // Software programs duty
	output reg sw_speed_mode_out, // Software programs speed
	output reg [1:0] fan_slow_out, // Count above slow limit
	output reg [2:0] temp_high_out, // Above upper limit
	output reg [2:0] temp_low_out, // Below lower limit
	output reg [2:0] temp_crit_out, // Above critical limit
	output reg int_n_out // Interrupt, active low
);
	localparam ST_IDLE = 4'h0;
	localparam ST_ADDR = 4'h1;
	localparam ST_ADDR_ACK = 4'h2;
	localparam ST_CMD = 4'h3;
	localparam ST_CMD_ACK = 4'h4;
	localparam ST_WDATA = 4'h5;
	localparam ST_WDATA_ACK = 4'h6;
	localparam ST_RDATA = 4'h7;
	localparam ST_RDATA_ACK = 4'h8;

	// ==========================================
	// Helper functions
	// Signed add that clips instead of wrapping
	function [7:0] tfv_sat_add;
		input [7:0] a;
		input [7:0] b;
		reg [8:0] s;
		begin
			s = {a[7], a} + {b[7], b};
			if (s[8] != s[7]) begin
				tfv_sat_add = s[8] ? `TFV_TEMP_MIN : `TFV_TEMP_MAX;
			end else begin
				tfv_sat_add = s[7:0];
			end
		end
	endfunction

	function tfv_gt;
		input [7:0] a;
		input [7:0] b;
		begin
			tfv_gt = $signed(a) > $signed(b);
		end
	endfunction

	function [7:0] tfv_max;
		input [7:0] a;
		input [7:0] b;
		begin
			tfv_max = tfv_gt(a, b) ? a : b;
		end
	endfunction

	// Interval to count, pinned at full scale
	function [7:0] tfv_tach;
		input [15:0] iv;
		input stall;
		begin
			if (stall || (iv[15:8] != `TFV_ZERO8)) begin
				tfv_tach = `TFV_TACH_SAT; // RULE_19
			end else begin
				tfv_tach = iv[7:0];
			end
		end
	endfunction

	// ==========================================
	// Register storage
	reg [7:0] cfg;
	reg [7:0] frac;
	reg [7:0] fan1_cnt;
	reg [7:0] fan2_cnt;
	reg [7:0] t_loc;
	reg [7:0] t_r1;
	reg [7:0] t_r2;
	reg [7:0] ofs_loc;
	reg [7:0] ofs_r1;
	reg [7:0] ofs_r2;
	reg [7:0] slow1;
	reg [7:0] slow2;
	reg [7:0] loc_up;
	reg [7:0] loc_lo;
	reg [7:0] loc_cr;
	reg [7:0] r1_up;
	reg [7:0] r1_lo;
	reg [7:0] r1_cr;
	reg [7:0] r2_up;
	reg [7:0] r2_lo;
	reg [7:0] r2_cr;

	// Bus slave state
	reg scl_s1, scl_s2, scl_d;
	reg sda_s1, sda_s2, sda_d;
	reg [3:0] state;
	reg [3:0] bitcnt;
	reg [7:0] sr;
	reg [7:0] tx;
	reg [7:0] pointer;
	reg rw;
	reg wr_stb;
	reg [7:0] wr_data;
	reg [7:0] rd_data;

	wire scl_rise = scl_s2 & ~scl_d;
	wire scl_fall = ~scl_s2 & scl_d;
	wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
	wire bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;

	// ==========================================
	// Pin synchronisers, idle high
	always @(posedge clock_in) begin
		if (rst_in) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_s1 <= scl_in;
			scl_s2 <= scl_s1;
			scl_d <= scl_s2;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
			sda_d <= sda_s2;
		end
	end

	// ==========================================
	// Byte-level slave: address, command byte, data bytes
	// Pointer does not advance, so repeated bytes hit one register
	always @(posedge clock_in) begin
		if (rst_in) begin
			state <= ST_IDLE;
			bitcnt <= `TFV_BIT_ZERO;
			sr <= `TFV_ZERO8;
			tx <= `TFV_ZERO8;
			pointer <= `TFV_ZERO8;
			rw <= 1'b0;
			wr_stb <= 1'b0;
			wr_data <= `TFV_ZERO8;
			sda_out <= 1'b0;
			sda_oe_out <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			if (bus_start) begin
				state <= ST_ADDR;
				bitcnt <= `TFV_BIT_ZERO;
				sda_oe_out <= 1'b0;
			end else if (bus_stop) begin
				state <= ST_IDLE;
				sda_oe_out <= 1'b0;
			end else if (scl_rise) begin
				case (state)
				ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA: begin
					sr <= {sr[6:0], sda_s2};
					bitcnt <= bitcnt + `TFV_BIT_ONE;
				end
				ST_RDATA_ACK: begin
					sr <= {sr[6:0], sda_s2};
				end
				default: begin
				end
				endcase
			end else if (scl_fall) begin
				case (state)
				ST_ADDR: begin
					if (bitcnt == `TFV_BIT_LAST) begin
						if (sr[7:1] == `TFV_DEV_ADDR) begin
							rw <= sr[0];
							sda_oe_out <= 1'b1;
							state <= ST_ADDR_ACK;
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK: begin
					bitcnt <= `TFV_BIT_ZERO;
					if (rw) begin
						tx <= rd_data;
						sda_oe_out <= ~rd_data[7];
						state <= ST_RDATA;
					end else begin
						sda_oe_out <= 1'b0;
						state <= ST_CMD;
					end
				end
				ST_CMD: begin
					if (bitcnt == `TFV_BIT_LAST) begin
						pointer <= sr;
						sda_oe_out <= 1'b1;
						state <= ST_CMD_ACK;
					end
				end
				ST_CMD_ACK, ST_WDATA_ACK: begin
					bitcnt <= `TFV_BIT_ZERO;
					sda_oe_out <= 1'b0;
					state <= ST_WDATA;
				end
				ST_WDATA: begin
					if (bitcnt == `TFV_BIT_LAST) begin
						wr_stb <= 1'b1;
						wr_data <= sr;
						sda_oe_out <= 1'b1;
						state <= ST_WDATA_ACK;
					end
				end
				ST_RDATA: begin
					if (bitcnt == `TFV_BIT_LAST) begin
						sda_oe_out <= 1'b0;
						state <= ST_RDATA_ACK;
					end else begin
						sda_oe_out <= ~tx[3'h7 - bitcnt[2:0]];
					end
				end
				ST_RDATA_ACK: begin
					// Host low means it wants another byte
					if (!sr[0]) begin
						bitcnt <= `TFV_BIT_ZERO;
						tx <= rd_data;
						sda_oe_out <= ~rd_data[7];
						state <= ST_RDATA;
					end else begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
				endcase
			end
		end
	end

	// ==========================================
	// Read mux; unmapped offsets read zero
	always @* begin
		case (pointer)
		`TFV_A_CFG: rd_data = cfg;
		`TFV_A_FRAC: rd_data = frac; // RULE_03
		`TFV_A_FAN1: rd_data = fan1_cnt; // RULE_01
		`TFV_A_FAN2: rd_data = fan2_cnt; // RULE_01
		`TFV_A_T_LOC: rd_data = t_loc; // RULE_02
		`TFV_A_T_R1: rd_data = t_r1; // RULE_02
		`TFV_A_T_R2: rd_data = t_r2; // RULE_02
		`TFV_A_OFS_LOC: rd_data = ofs_loc;
		`TFV_A_OFS_R1: rd_data = ofs_r1;
		`TFV_A_OFS_R2: rd_data = ofs_r2;
		`TFV_A_SLOW1: rd_data = slow1;
		`TFV_A_SLOW2: rd_data = slow2;
		`TFV_A_LOC_UP: rd_data = loc_up;
		`TFV_A_LOC_LO: rd_data = loc_lo;
		`TFV_A_LOC_CR: rd_data = loc_cr;
		`TFV_A_R1_UP: rd_data = r1_up;
		`TFV_A_R1_LO: rd_data = r1_lo;
		`TFV_A_R1_CR: rd_data = r1_cr;
		`TFV_A_R2_UP: rd_data = r2_up;
		`TFV_A_R2_LO: rd_data = r2_lo;
		`TFV_A_R2_CR: rd_data = r2_cr;
		default: rd_data = `TFV_ZERO8;
		endcase
	end

	// ==========================================
	// Writable registers; read-only offsets ignore writes
	always @(posedge clock_in) begin
		if (rst_in) begin
			cfg <= `TFV_CFG_RST; // RULE_18
			ofs_loc <= `TFV_OFS_RST; // RULE_04
			ofs_r1 <= `TFV_OFS_RST; // RULE_04
			ofs_r2 <= `TFV_OFS_RST; // RULE_04
			slow1 <= `TFV_SLOW_RST; // RULE_06
			slow2 <= `TFV_SLOW_RST; // RULE_06
			loc_up <= `TFV_LOC_UP_RST; // RULE_07
			loc_lo <= `TFV_LOC_LO_RST; // RULE_07
			loc_cr <= `TFV_LOC_CR_RST; // RULE_07
			r1_up <= `TFV_REM_UP_RST; // RULE_08
			r1_lo <= `TFV_REM_LO_RST; // RULE_08
			r1_cr <= `TFV_REM_CR_RST; // RULE_08
			r2_up <= `TFV_REM_UP_RST; // RULE_09
			r2_lo <= `TFV_REM_LO_RST; // RULE_09
			r2_cr <= `TFV_REM_CR_RST; // RULE_09
		end else if (wr_stb) begin
			case (pointer)
			`TFV_A_CFG: cfg <= wr_data;
			`TFV_A_OFS_LOC: ofs_loc <= wr_data;
			`TFV_A_OFS_R1: ofs_r1 <= wr_data;
			`TFV_A_OFS_R2: ofs_r2 <= wr_data;
			`TFV_A_SLOW1: slow1 <= wr_data;
			`TFV_A_SLOW2: slow2 <= wr_data;
			`TFV_A_LOC_UP: loc_up <= wr_data;
			`TFV_A_LOC_LO: loc_lo <= wr_data;
			`TFV_A_LOC_CR: loc_cr <= wr_data;
			`TFV_A_R1_UP: r1_up <= wr_data;
			`TFV_A_R1_LO: r1_lo <= wr_data;
			`TFV_A_R1_CR: r1_cr <= wr_data;
			`TFV_A_R2_UP: r2_up <= wr_data;
			`TFV_A_R2_LO: r2_lo <= wr_data;
			`TFV_A_R2_CR: r2_cr <= wr_data;
			default: begin
			end
			endcase
		end
	end

	// ==========================================
	// Measurement registers; fresh data beats a host write
	always @(posedge clock_in) begin
		if (rst_in) begin
			fan1_cnt <= `TFV_TACH_SAT;
			fan2_cnt <= `TFV_TACH_SAT;
			t_loc <= `TFV_ZERO8;
			t_r1 <= `TFV_ZERO8;
			t_r2 <= `TFV_ZERO8;
			frac <= `TFV_ZERO8;
		end else begin
			if (cfg[`TFV_B_MON] && fan_valid_in[0]) begin
				fan1_cnt <= tfv_tach(fan1_interval_in, fan_stall_in[0]); // RULE_10
			end else if (wr_stb && pointer == `TFV_A_FAN1) begin
				fan1_cnt <= wr_data; // RULE_01
			end
			if (cfg[`TFV_B_MON] && fan_valid_in[1]) begin
				fan2_cnt <= tfv_tach(fan2_interval_in, fan_stall_in[1]); // RULE_10
			end else if (wr_stb && pointer == `TFV_A_FAN2) begin
				fan2_cnt <= wr_data; // RULE_01
			end
			if (cfg[`TFV_B_MON] && temp_valid_in) begin
				t_loc <= temp_loc_in; // RULE_10
				t_r1 <= temp_r1_in;
				t_r2 <= temp_r2_in;
				frac <= temp_frac_in;
			end
		end
	end

	// ==========================================
	// Offset-corrected temperatures, signed
	wire [7:0] e_loc = tfv_sat_add(t_loc, ofs_loc); // RULE_21
	wire [7:0] e_r1 = tfv_sat_add(t_r1, ofs_r1); // RULE_21
	wire [7:0] e_r2 = tfv_sat_add(t_r2, ofs_r2); // RULE_21
	wire [7:0] e_max = tfv_max(e_loc, tfv_max(e_r1, e_r2));
	wire [1:0] slow = {fan2_cnt > slow2, fan1_cnt > slow1}; // RULE_05
	wire [1:0] map = cfg[`TFV_B_MAP_HI:`TFV_B_MAP_LO];
	reg [1:0] next_src1;
	reg [1:0] next_src2;

	// Automatic channel steering per fan
	always @* begin
		case (map) // RULE_15
		`TFV_MAP_SPLIT: begin
			next_src1 = `TFV_SRC_R1;
			next_src2 = `TFV_SRC_R2;
		end
		`TFV_MAP_R1: begin
			next_src1 = `TFV_SRC_R1;
			next_src2 = `TFV_SRC_R1;
		end
		`TFV_MAP_R2: begin
			next_src1 = `TFV_SRC_R2;
			next_src2 = `TFV_SRC_R2;
		end
		default: begin
			next_src1 = `TFV_SRC_MAX;
			next_src2 = `TFV_SRC_MAX;
		end
		endcase
	end

	// ==========================================
	// Registered outputs toward pins and the control loop
	always @(posedge clock_in) begin
		if (rst_in) begin
			fan_drive_out <= 2'h0;
			monitor_enable_out <= 1'b0;
			speed_sense_select_out <= 1'b0;
			fan_fault_enable_out <= 1'b1;
			automatic_control_select_out <= 1'b1;
			fan1_source_out <= `TFV_SRC_R1;
			fan2_source_out <= `TFV_SRC_R2;
			fan1_control_temp_out <= `TFV_ZERO8;
			fan2_control_temp_out <= `TFV_ZERO8;
			sw_duty_mode_out <= 1'b0;
			sw_speed_mode_out <= 1'b0;
			fan_slow_out <= 2'h0;
			temp_high_out <= 3'h0;
			temp_low_out <= 3'h0;
			temp_crit_out <= 3'h0;
			int_n_out <= 1'b1;
		end else begin
			fan_drive_out <= fan_drive_in ^ {2{cfg[`TFV_B_INV]}}; // RULE_13
			monitor_enable_out <= cfg[`TFV_B_MON]; // RULE_10
			speed_sense_select_out <= cfg[`TFV_B_SENSE]; // RULE_12
			fan_fault_enable_out <= cfg[`TFV_B_FFEN]; // RULE_14
			automatic_control_select_out <= cfg[`TFV_B_AUTO]; // RULE_17
			fan1_source_out <= next_src1;
			fan2_source_out <= next_src2;
			fan1_control_temp_out <= (next_src1 == `TFV_SRC_MAX) ? e_max : e_r1;
			case (next_src2)
			`TFV_SRC_R1: fan2_control_temp_out <= e_r1;
			`TFV_SRC_R2: fan2_control_temp_out <= e_r2;
			default: fan2_control_temp_out <= e_max;
			endcase
			if (next_src1 == `TFV_SRC_R2) begin
				fan1_control_temp_out <= e_r2;
			end
			// Codes 01 and 10 in software mode fall back to direct duty
			sw_duty_mode_out <= ~cfg[`TFV_B_AUTO] & (map != `TFV_MAP_MAX); // RULE_16
			sw_speed_mode_out <= ~cfg[`TFV_B_AUTO] & (map == `TFV_MAP_MAX); // RULE_16
			fan_slow_out <= slow; // RULE_05
			temp_high_out <= {tfv_gt(e_r2, r2_up), tfv_gt(e_r1, r1_up),
				tfv_gt(e_loc, loc_up)}; // RULE_21
			temp_low_out <= {tfv_gt(r2_lo, e_r2), tfv_gt(r1_lo, e_r1),
				tfv_gt(loc_lo, e_loc)}; // RULE_21
			temp_crit_out <= {tfv_gt(e_r2, r2_cr), tfv_gt(e_r1, r1_cr),
				tfv_gt(e_loc, loc_cr)}; // RULE_21
			// Level interrupt; follows the counts, no latch here
			int_n_out <= ~(cfg[`TFV_B_INTEN] & (|slow)); // RULE_11 RULE_20
		end
	end
endmodule
`default_nettype wire

// [tfv_value_config_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checks for the value and configuration bank
module tfv_value_config_chk (
	input wire logic clock_in, // Clock
	input wire logic rst_in, // Reset
	input wire logic [1:0] fan_drive_in, // Raw drive
	input wire logic [1:0] fan_drive_out, // Drive out
	input wire logic monitor_enable_out, // Monitor
	input wire logic speed_sense_select_out, // Sense
	input wire logic fan_fault_enable_out, // Fault pin
	input wire logic automatic_control_select_out, // Auto
	input wire logic [1:0] fan1_source_out, // Source one
	input wire logic [1:0] fan2_source_out, // Source two
	input wire logic [7:0] fan1_control_temp_out, // Temp one
	input wire logic [7:0] fan2_control_temp_out, // Temp two
	input wire logic sw_duty_mode_out, // Duty mode
	input wire logic sw_speed_mode_out, // Speed mode
	input wire logic [1:0] fan_slow_out, // Slow flags
	input wire logic [2:0] temp_high_out, // Upper flags
	input wire logic [2:0] temp_low_out, // Lower flags
	input wire logic [2:0] temp_crit_out, // Critical flags
	input wire logic int_n_out // Interrupt
);
	default clocking cb @(posedge clock_in);
	endclocking
	// First sample after reset lets go
	sequence s_release;
		$fell(rst_in);
	endsequence
	// Both fans steered alike long enough for the temperature path
	sequence s_same_src;
		(fan1_source_out == fan2_source_out) [*3];
	endsequence
	AST_RST_CFG:
		assert property (disable iff (rst_in) s_release |-> automatic_control_select_out
			&& fan_fault_enable_out) else $error("config defaults wrong");
	AST_RST_MON:
		assert property (disable iff (rst_in) s_release |-> !monitor_enable_out
			&& !speed_sense_select_out) else $error("monitor or sense set after reset");
	AST_RST_INT:
		assert property (disable iff (rst_in) s_release |-> int_n_out)
			else $error("interrupt active after reset");
	AST_RST_LIM:
		assert property (disable iff (rst_in) s_release |-> temp_high_out == 3'h0
			&& temp_low_out == 3'h0 && temp_crit_out == 3'h0) else $error("limit flag after reset");
	AST_RST_SLOW:
		assert property (disable iff (rst_in) s_release |-> fan_slow_out == 2'h0)
			else $error("slow flag after reset");
	AST_INV_PAIR:
		assert property (disable iff (rst_in) !$past(rst_in) |->
			(fan_drive_out ^ $past(fan_drive_in)) inside {2'h0, 2'h3})
			else $error("fan outputs not inverted together");
	AST_INT_CAUSE:
		assert property (disable iff (rst_in) !int_n_out |-> fan_slow_out != 2'h0
			|| $past(fan_slow_out) != 2'h0) else $error("interrupt without slow fan");
	AST_SRC_SPLIT:
		assert property (disable iff (rst_in) automatic_control_select_out
			&& fan1_source_out != fan2_source_out |-> fan1_source_out == 2'h1
			&& fan2_source_out == 2'h2) else $error("bad split steering");
	AST_SW_AUTO:
		assert property (@(posedge clock_in) disable iff (rst_in) automatic_control_select_out
			|-> !sw_duty_mode_out && !sw_speed_mode_out) else $error("software mode in auto");
	AST_SW_EXCL:
		assert property (disable iff (rst_in) !automatic_control_select_out
			|-> sw_duty_mode_out != sw_speed_mode_out) else $error("software mode not unique");
	AST_SAME_TEMP:
		assert property (disable iff (rst_in) s_same_src |->
			fan1_control_temp_out == fan2_control_temp_out) else $error("shared source differs");
endmodule
`default_nettype wire

// [tfv_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Two-wire bus host, bit-banged at a slow pace
module tfv_host_model (
	input wire logic clock_in, // Pacing clock
	input wire logic sda_in, // Resolved data wire
	output logic scl_out, // Bus clock
	output logic sda_low_out // High pulls data low
);
	localparam logic [6:0] DEV = 7'h2c; // Device address
	// Idle bus: both lines released
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	// Six clocks a phase, well over the synchroniser delay
	task automatic half();
		repeat (6) @(posedge clock_in);
		#1;
	endtask
	// Works from idle and as a repeated start
	task automatic start();
		sda_low_out = 1'b0;
		half();
		scl_out = 1'b1;
		half();
		sda_low_out = 1'b1;
		half();
		scl_out = 1'b0;
		half();
	endtask
	task automatic stop();
		sda_low_out = 1'b1;
		half();
		scl_out = 1'b1;
		half();
		sda_low_out = 1'b0;
		half();
	endtask
	// Data only moves while clock is low; ninth bit always released
	task automatic xfer(input logic [7:0] d, output logic [7:0] q);
		for (int i = 8; i >= 0; i--) begin
			sda_low_out = (i > 0) ? !d[(i + 7) % 8] : 1'b0;
			half();
			scl_out = 1'b1;
			half();
			if (i > 0)
				q[(i + 7) % 8] = sda_in;
			scl_out = 1'b0;
			half();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		start();
		xfer({DEV, 1'b0}, q);
		xfer(a, q);
		xfer(d, q);
		stop();
	endtask
	// Pointer write, repeated start, one byte then not-acknowledge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] q;
		start();
		xfer({DEV, 1'b0}, q);
		xfer(a, q);
		start();
		xfer({DEV, 1'b1}, q);
		xfer(8'hff, d);
		stop();
	endtask
endmodule
`default_nettype wire

// [test_tfv_value_config.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Self-checking bench
module test_tfv_value_config;
	logic clock_in, rst_in, scl, host_low, sda_oe, sda_o, tvalid;
	logic [15:0] iv1, iv2, obs_val;
	logic [1:0] fvalid, fstall, drv_in, drv_out, slow, src1, src2;
	logic [7:0] tl, t1, t2, tf, ct1, ct2, rd, c, d;
	logic [2:0] thi, tlo, tcr;
	logic mon, sense, ffen, autos, duty, speed, int_n;
	int fail_count = 0;
	int tests_run = 0;
	int unsigned seed;
	logic [15:0] exp_q[$];
	event obs_ev;
	logic [7:0] ra [0:21] = '{8'h00, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e,
		8'h0f, 8'h10, 8'h11, 8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1a, 8'h1c, 8'h1d, 8'h1e, 8'h07};
	logic [7:0] rv [0:21] = '{8'h90, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'hff, 8'hff, 8'h3c, 8'h00, 8'h46, 8'h50, 8'h00, 8'h64, 8'h50, 8'h00, 8'h64, 8'h00};
	wire sda = ~(host_low | sda_oe); // Pull-up unless a side pulls low
	tfv_value_config dut (.clock_in(clock_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_o), .sda_oe_out(sda_oe), .fan1_interval_in(iv1), .fan2_interval_in(iv2),
		.fan_valid_in(fvalid), .fan_stall_in(fstall), .temp_loc_in(tl), .temp_r1_in(t1),
		.temp_r2_in(t2), .temp_frac_in(tf), .temp_valid_in(tvalid), .fan_drive_in(drv_in),
		.fan_drive_out(drv_out), .monitor_enable_out(mon), .speed_sense_select_out(sense),
		.fan_fault_enable_out(ffen), .automatic_control_select_out(autos),
		.fan1_source_out(src1), .fan2_source_out(src2), .fan1_control_temp_out(ct1),
		.fan2_control_temp_out(ct2), .sw_duty_mode_out(duty), .sw_speed_mode_out(speed),
		.fan_slow_out(slow), .temp_high_out(thi), .temp_low_out(tlo), .temp_crit_out(tcr),
		.int_n_out(int_n));
	tfv_host_model host (.clock_in(clock_in), .sda_in(sda), .scl_out(scl), .sda_low_out(host_low));
	// ==========================================
	// Clock, watchdog, result watcher
	initial begin
		clock_in = 1'b0;
		forever #2.5 clock_in = ~clock_in;
	end
	// Whole run needs about 62k cycles
	initial begin
		repeat (95000) @(posedge clock_in);
		fail_count++;
		results();
	end
	initial forever begin
		@(obs_ev);
		check(obs_val, exp_q.pop_front());
	end
	// ==========================================
	// Tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		tests_run++;
		if (seen !== want) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, want);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// The #1 keeps two observations out of one time step
	task automatic observe(input logic [15:0] v);
		obs_val = v;
		->obs_ev;
		#1;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back({8'h00, e});
		host.rd(a, rd);
		observe({8'h00, rd});
	endtask
	task automatic fan_chk(input logic [2:0] e);
		exp_q.push_back({13'h0000, e});
		repeat (3) @(posedge clock_in);
		observe({13'h0000, slow, int_n});
	endtask
	task automatic do_reset();
		rst_in = 1'b1;
		repeat (20) @(posedge clock_in);
		#1 rst_in = 1'b0;
		repeat (8) @(posedge clock_in);
		#1;
	endtask
	// One-cycle measurement strobes, then let flags settle
	task automatic strobe(input logic [1:0] f, input logic t);
		@(posedge clock_in);
		#1 fvalid = f;
		tvalid = t;
		@(posedge clock_in);
		#1 fvalid = 2'h0;
		tvalid = 1'b0;
		repeat (4) @(posedge clock_in);
		#1;
	endtask
	// Outputs steered by the configuration byte; sources only matter in auto
	function automatic logic [15:0] cfg_view(input logic [7:0] v);
		logic [3:0] s;
		s = (v[6:5] == 2'h0) ? 4'h6 : (v[6:5] == 2'h1) ? 4'h5 : (v[6:5] == 2'h2) ? 4'ha : 4'hf;
		return {6'h00, v[0], v[2], v[4], v[7], !v[7] && v[6:5] != 2'h3, !v[7] && v[6:5] == 2'h3,
			v[7] ? s : 4'h0};
	endfunction
	// ==========================================
	// Main sequence
	initial begin
		rst_in = 1'b1;
		{iv1, iv2, fvalid, fstall, tvalid, drv_in} = '0;
		{tl, t1, t2, tf} = '0;
		seed = $urandom(1540);
		do_reset();
		for (int i = 0; i < 22; i++)
			rd_chk(ra[i], rv[i]);
		$display("test reset_values done");
		for (int i = 1; i < 22; i++) begin
			d = 8'($urandom);
			host.wr(ra[i], d);
			rd_chk(ra[i], (i inside {1, 4, 5, 6, 21}) ? 8'h00 : d);
		end
		$display("test read_write done");
		for (int i = 0; i < 8; i++) begin
			c = {i[2], i[1:0], 5'($urandom)};
			host.wr(8'h00, c);
			rd_chk(8'h00, c);
			exp_q.push_back(cfg_view(c));
			observe({6'h00, mon, sense, ffen, autos, duty, speed, c[7] ? {src1, src2} : 4'h0});
		end
		$display("test config_modes done");
		// Signed offsets and limits, saturating and stalled counts
		do_reset();
		host.wr(8'h15, 8'h05);
		host.wr(8'h0d, 8'hfb);
		host.wr(8'h10, 8'h80);
		host.wr(8'h00, 8'h93);
		iv1 = 16'd300;
		iv2 = 16'h0020;
		{tl, t1, t2} = {8'h08, 8'hf6, 8'h65};
		tf = 8'($urandom);
		strobe(2'h3, 1'b1);
		exp_q.push_back({4'h0, 2'h1, 1'h0, 3'h4, 3'h3, 3'h4});
		observe({4'h0, slow, int_n, thi, tlo, tcr});
		rd_chk(8'h08, 8'hff);
		rd_chk(8'h09, 8'h20);
		rd_chk(8'h0a, 8'h08);
		rd_chk(8'h0b, 8'hf6);
		rd_chk(8'h0c, 8'h65);
		rd_chk(8'h06, tf);
		exp_q.push_back({8'hf6, 8'h65});
		observe({ct1, ct2});
		host.wr(8'h00, 8'hf3);
		exp_q.push_back({8'h65, 8'h65});
		observe({ct1, ct2});
		@(posedge clock_in);
		#1 fstall = 2'h2;
		strobe(2'h2, 1'b0);
		rd_chk(8'h09, 8'hff);
		fan_chk(3'h2);
		host.wr(8'h00, 8'h91);
		fan_chk(3'h3);
		host.wr(8'h08, 8'h10);
		fan_chk(3'h1);
		host.wr(8'h00, 8'h98);
		fstall = 2'h0;
		iv1 = 16'h0005;
		strobe(2'h1, 1'b0);
		rd_chk(8'h08, 8'h10);
		@(posedge clock_in);
		#1 drv_in = 2'h1;
		repeat (3) @(posedge clock_in);
		#1 exp_q.push_back(16'h0002);
		observe({14'h0000, drv_out});
		exp_q.push_back(16'h0000);
		observe({15'h0000, sda_o});
		$display("test measurement done");
		results();
	end
endmodule
bind tfv_value_config tfv_value_config_chk chk (.clock_in(clock_in), .rst_in(rst_in),
	.fan_drive_in(fan_drive_in), .fan_drive_out(fan_drive_out),
	.monitor_enable_out(monitor_enable_out), .speed_sense_select_out(speed_sense_select_out),
	.fan_fault_enable_out(fan_fault_enable_out),
	.automatic_control_select_out(automatic_control_select_out),
	.fan1_source_out(fan1_source_out), .fan2_source_out(fan2_source_out),
	.fan1_control_temp_out(fan1_control_temp_out), .fan2_control_temp_out(fan2_control_temp_out),
	.sw_duty_mode_out(sw_duty_mode_out), .sw_speed_mode_out(sw_speed_mode_out),
	.fan_slow_out(fan_slow_out), .temp_high_out(temp_high_out), .temp_low_out(temp_low_out),
	.temp_crit_out(temp_crit_out), .int_n_out(int_n_out));
`default_nettype wire
